// *** hdl/qpi_pkg.sv ***
// Shared constants for the quad wiper two-wire link and its master.
// Assumes a 20 MHz system clock on both ends.
package qpi_pkg;
	localparam int NUM_WIPERS = 4;
	localparam int WIPER_W = 8;
	localparam int PTR_W = 2;
	localparam logic [7:0] WIPER_RESET = 8'h80;
	localparam logic [7:0] LAST_REG = 8'h03;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// Device type code, arbitrary value
	localparam logic [4:0] TYPE_CODE = 5'h13;
	localparam int ID_TYPE_MSB = 7;
	localparam int ID_TYPE_LSB = 3;
	localparam int ID_HI_BIT = 2;
	localparam int ID_LO_BIT = 1;
	localparam int ID_DIR_BIT = 0;
	localparam logic DIR_READ = 1'b1;
	localparam logic DIR_WRITE = 1'b0;
	localparam logic [1:0] SETTLE_CYC = 2'h3;
	////////////////////////////////////////////////////////////////////////////
	localparam int CLK_PERIOD_NS = 50;
	localparam int SCL_HALF_NS = 200;
	localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W = 3;
	localparam logic [TIMER_W-1:0] HALF_RELOAD = TIMER_W'(SCL_HALF_CYC - 1);
	////////////////////////////////////////////////////////////////////////////
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_TADDR = 3'h1;
	localparam logic [2:0] REG_WDATA = 3'h2;
	localparam logic [2:0] REG_STRAP = 3'h3;
	localparam logic [2:0] REG_STATUS = 3'h4;
	localparam logic [2:0] REG_RDATA = 3'h5;
	localparam int CTRL_GO = 0;
	localparam int CTRL_RD = 1;
	localparam int CTRL_CNT_LSB = 2;
	localparam int CTRL_CNT_MSB = 3;
	localparam int STAT_BUSY = 0;
	localparam int STAT_NACK = 1;
endpackage

// *** hdl/qpi_if.sv ***
// Two-wire link between master and wiper device.
// Both lines are open drain with pull-ups; an enable pulls the line low.
`timescale 1ns/1ps
interface qpi_if;
	logic hostSclOe;
	logic hostSdaOe;
	logic devSdaOe;
	wire scl;
	wire sda;
	assign scl = !hostSclOe;
	assign sda = !(hostSdaOe || devSdaOe);
	modport host (output hostSclOe, output hostSdaOe, input scl, input sda);
	modport dev (output devSdaOe, input scl, input sda);
endinterface

// *** hdl/qpi_device.sv ***
// Slave end: four wiper registers behind the two-wire link.
// Assumes link lines arrive asynchronously and the master drives the clock.
`timescale 1ns/1ps
// Notes on behaviour
// - Wipers reset to 80h
// - Address byte 00h..03h picks a wiper
// - Slave only, clock comes from master
// - Bytes travel most significant bit first
// - Master changes data only while clock low
// - Data pin released after reset
// - Ignore traffic until a START
// - START ignored while still powering up
// - STOP returns device to standby
// - Transmitter releases; receiver pulls ninth bit low
// - Acknowledge valid ID, address, write data
// - Master acknowledges read bytes wanting more
// - ID valid when type code and straps match
// - ID lowest bit: 1 read, 0 write
// - Write: START, ID, address, data, STOP
// - Read: ID, address, repeated START, ID read
// - Keep sending while master acknowledges
// - Pointer loads from address, increments per read byte
// - Pointer wraps from 03h to 00h
// - Each wiper is an 8-bit register
module qpi_device (
	input wire logic clk,
	input wire logic srst,
	qpi_if.dev bus,
	input wire logic addrStrapHi,
	input wire logic addrStrapLo,
	output logic [qpi_pkg::NUM_WIPERS-1:0][qpi_pkg::WIPER_W-1:0] wiperPos
);
	typedef enum logic [3:0] {
		D_IDLE, D_ID, D_ID_ACK, D_ADDR, D_ADDR_ACK,
		D_WDATA, D_WDATA_ACK, D_RDATA, D_RACK, D_IGNORE
	} qpi_dev_state_e;

	typedef struct packed {
		logic sclS1;
		logic sclS2;
		logic sclPrev;
		logic sdaS1;
		logic sdaS2;
		logic sdaPrev;
		logic [1:0] strapS1;
		logic [1:0] strapS2;
		logic [1:0] settle;
		qpi_dev_state_e st;
		logic [3:0] bitCnt;
		logic [7:0] shift;
		logic [qpi_pkg::PTR_W-1:0] ptr;
		logic rw;
		logic masterAck;
		logic sdaOe;
		logic [qpi_pkg::NUM_WIPERS-1:0][qpi_pkg::WIPER_W-1:0] wiper;
	} qpi_dev_s;

	qpi_dev_s s_r;
	qpi_dev_s s_nxt;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;
	logic settled;
	logic byteDone;
	logic idValid;

	////////////////////////////////////////////////////////////////////////////
	// Line events from synchronised samples
	assign sclRise = s_r.sclS2 && !s_r.sclPrev;
	assign sclFall = !s_r.sclS2 && s_r.sclPrev;
	assign startSeen = s_r.sclS2 && s_r.sclPrev && s_r.sdaPrev && !s_r.sdaS2;
	assign stopSeen = s_r.sclS2 && s_r.sclPrev && !s_r.sdaPrev && s_r.sdaS2;
	assign settled = (s_r.settle == qpi_pkg::SETTLE_CYC);
	assign byteDone = sclFall && (s_r.bitCnt == qpi_pkg::BITS_PER_BYTE);
	assign idValid = (s_r.shift[qpi_pkg::ID_TYPE_MSB:qpi_pkg::ID_TYPE_LSB] == qpi_pkg::TYPE_CODE)
		&& (s_r.shift[qpi_pkg::ID_HI_BIT] == s_r.strapS2[1])
		&& (s_r.shift[qpi_pkg::ID_LO_BIT] == s_r.strapS2[0]);

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_nxt = s_r;
		s_nxt.sclS1 = bus.scl;
		s_nxt.sclS2 = s_r.sclS1;
		s_nxt.sclPrev = s_r.sclS2;
		s_nxt.sdaS1 = bus.sda;
		s_nxt.sdaS2 = s_r.sdaS1;
		s_nxt.sdaPrev = s_r.sdaS2;
		s_nxt.strapS1 = {addrStrapHi, addrStrapLo};
		s_nxt.strapS2 = s_r.strapS1;
		if (!settled) begin
			s_nxt.settle = s_r.settle + 2'h1;
		end
		if (stopSeen) begin
			s_nxt.st = D_IDLE;
			s_nxt.sdaOe = 1'b0;
		end else if (startSeen && settled) begin
			// Repeated START lands here too and keeps the pointer
			s_nxt.st = D_ID;
			s_nxt.bitCnt = 4'h0;
			s_nxt.sdaOe = 1'b0;
		end else begin
			case (s_r.st)
				D_ID, D_ADDR, D_WDATA: begin
					// Clock only sampled, never driven
					if (sclRise) begin
						s_nxt.shift = {s_r.shift[6:0], s_r.sdaS2};
						s_nxt.bitCnt = s_r.bitCnt + 4'h1;
					end else if (byteDone) begin
						s_nxt.bitCnt = 4'h0;
						if (s_r.st == D_ID) begin
							if (idValid) begin
								s_nxt.rw = s_r.shift[qpi_pkg::ID_DIR_BIT];
								s_nxt.sdaOe = 1'b1;
								s_nxt.st = D_ID_ACK;
							end else begin
								s_nxt.st = D_IGNORE;
							end
						end else if (s_r.st == D_ADDR) begin
							if (s_r.shift <= qpi_pkg::LAST_REG) begin
								s_nxt.ptr = s_r.shift[qpi_pkg::PTR_W-1:0];
								s_nxt.sdaOe = 1'b1;
								s_nxt.st = D_ADDR_ACK;
							end else begin
								s_nxt.st = D_IGNORE;
							end
						end else begin
							s_nxt.wiper[s_r.ptr] = s_r.shift;
							s_nxt.sdaOe = 1'b1;
							s_nxt.st = D_WDATA_ACK;
						end
					end
				end
				D_ID_ACK: begin
					if (sclFall) begin
						if (s_r.rw == qpi_pkg::DIR_READ) begin
							s_nxt.shift = s_r.wiper[s_r.ptr];
							s_nxt.sdaOe = !s_r.wiper[s_r.ptr][7];
							s_nxt.st = D_RDATA;
						end else begin
							s_nxt.sdaOe = 1'b0;
							s_nxt.st = D_ADDR;
						end
					end
				end
				D_ADDR_ACK: begin
					if (sclFall) begin
						s_nxt.sdaOe = 1'b0;
						s_nxt.st = D_WDATA;
					end
				end
				D_WDATA_ACK: begin
					// Single byte write; later bytes are not taken
					if (sclFall) begin
						s_nxt.sdaOe = 1'b0;
						s_nxt.st = D_IGNORE;
					end
				end
				D_RDATA: begin
					if (sclRise) begin
						s_nxt.bitCnt = s_r.bitCnt + 4'h1;
					end else if (byteDone) begin
						s_nxt.bitCnt = 4'h0;
						s_nxt.sdaOe = 1'b0;
						// Two-bit pointer rolls 3 to 0
						s_nxt.ptr = s_r.ptr + 2'h1;
						s_nxt.st = D_RACK;
					end else if (sclFall) begin
						s_nxt.shift = {s_r.shift[6:0], 1'b0};
						s_nxt.sdaOe = !s_r.shift[6];
					end
				end
				D_RACK: begin
					if (sclRise) begin
						s_nxt.masterAck = !s_r.sdaS2;
					end else if (sclFall) begin
						if (s_r.masterAck) begin
							s_nxt.shift = s_r.wiper[s_r.ptr];
							s_nxt.sdaOe = !s_r.wiper[s_r.ptr][7];
							s_nxt.st = D_RDATA;
						end else begin
							s_nxt.st = D_IGNORE;
						end
					end
				end
				default: begin
					s_nxt.sdaOe = 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (srst) begin
			s_r <= '0;
			s_r.sclS1 <= 1'b1;
			s_r.sclS2 <= 1'b1;
			s_r.sclPrev <= 1'b1;
			s_r.sdaS1 <= 1'b1;
			s_r.sdaS2 <= 1'b1;
			s_r.sdaPrev <= 1'b1;
			s_r.st <= D_IDLE;
			s_r.sdaOe <= 1'b0;
			s_r.wiper <= {qpi_pkg::NUM_WIPERS{qpi_pkg::WIPER_RESET}};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign bus.devSdaOe = s_r.sdaOe;
	assign wiperPos = s_r.wiper;
endmodule

// *** hdl/qpi_host.sv ***
// Master end: runs single writes and burst reads on the two-wire link.
// Assumes software drives it over Avalon-MM with waitrequest.
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
module qpi_host (
	input wire logic clk,
	input wire logic srst,
	input wire logic [2:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	qpi_if.host bus
);
	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} qpi_host_state_e;
	typedef enum logic [2:0] {S_ID, S_ADDR, S_WDATA, S_ID2, S_RD} qpi_step_e;

	typedef struct packed {
		logic sdaS1;
		logic sdaS2;
		qpi_host_state_e st;
		qpi_step_e step;
		logic [1:0] phase;
		logic [qpi_pkg::TIMER_W-1:0] timer;
		logic [7:0] tx;
		logic [3:0] bitCnt;
		logic isRead;
		logic [1:0] rdIdx;
		logic [1:0] rdLast;
		logic [31:0] rdata;
		logic nack;
		logic [7:0] regAddr;
		logic [7:0] wdata;
		logic [1:0] strap;
		logic resp;
		logic [31:0] rdReg;
		logic sclOe;
		logic sdaOe;
	} qpi_host_s;

	qpi_host_s s_r;
	qpi_host_s s_nxt;

	function automatic logic [7:0] idByte(input logic [1:0] strap, input logic dir);
		idByte = {qpi_pkg::TYPE_CODE, strap, dir};
	endfunction

	// Line drive for a given state; returns {sclOe, sdaOe}
	function automatic logic [1:0] lineDrive(input qpi_host_s h);
		logic rx;
		rx = (h.step == S_RD);
		lineDrive = 2'h0;
		case (h.st)
			H_START: begin
				lineDrive = {h.phase == 2'h0 || h.phase == 2'h3, h.phase >= 2'h2};
			end
			H_STOP: begin
				lineDrive = {h.phase == 2'h0, h.phase != 2'h2};
			end
			H_BIT: begin
				if (h.bitCnt < qpi_pkg::BITS_PER_BYTE) begin
					lineDrive = {h.phase == 2'h0, !rx && !h.tx[7]};
				end else begin
					lineDrive = {h.phase == 2'h0, rx && (h.rdIdx != h.rdLast)};
				end
			end
			default: begin
				lineDrive = 2'h0;
			end
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_nxt = s_r;
		s_nxt.sdaS1 = bus.sda;
		s_nxt.sdaS2 = s_r.sdaS1;
		s_nxt.resp = (read || write) && !s_r.resp;
		if (read && !s_r.resp) begin
			if (address == qpi_pkg::REG_CTRL) begin
				s_nxt.rdReg = 32'({s_r.rdLast, s_r.isRead, 1'b0});
			end else if (address == qpi_pkg::REG_TADDR) begin
				s_nxt.rdReg = 32'(s_r.regAddr);
			end else if (address == qpi_pkg::REG_WDATA) begin
				s_nxt.rdReg = 32'(s_r.wdata);
			end else if (address == qpi_pkg::REG_STRAP) begin
				s_nxt.rdReg = 32'(s_r.strap);
			end else if (address == qpi_pkg::REG_STATUS) begin
				s_nxt.rdReg = 32'({s_r.nack, s_r.st != H_IDLE});
			end else if (address == qpi_pkg::REG_RDATA) begin
				s_nxt.rdReg = s_r.rdata;
			end else begin
				s_nxt.rdReg = 32'h0;
			end
		end
		if (write && s_r.resp) begin
			if (address == qpi_pkg::REG_TADDR) begin
				s_nxt.regAddr = writedata[7:0];
			end else if (address == qpi_pkg::REG_WDATA) begin
				s_nxt.wdata = writedata[7:0];
			end else if (address == qpi_pkg::REG_STRAP) begin
				s_nxt.strap = writedata[1:0];
			end else if (address == qpi_pkg::REG_CTRL && writedata[qpi_pkg::CTRL_GO]
				&& s_r.st == H_IDLE) begin
				s_nxt.isRead = writedata[qpi_pkg::CTRL_RD];
				s_nxt.rdLast = writedata[qpi_pkg::CTRL_CNT_MSB:qpi_pkg::CTRL_CNT_LSB];
				s_nxt.rdIdx = 2'h0;
				s_nxt.nack = 1'b0;
				s_nxt.step = S_ID;
				s_nxt.tx = idByte(s_r.strap, qpi_pkg::DIR_WRITE);
				s_nxt.st = H_START;
				s_nxt.phase = 2'h0;
				s_nxt.timer = qpi_pkg::HALF_RELOAD;
			end
		end
		////////////////////////////////////////////////////////////////////////
		// Link engine, master owns the clock
		if (s_r.st != H_IDLE) begin
			if (s_r.timer != '0) begin
				s_nxt.timer = s_r.timer - qpi_pkg::TIMER_W'(1);
			end else begin
				s_nxt.timer = qpi_pkg::HALF_RELOAD;
				case (s_r.st)
					H_START: begin
						s_nxt.phase = s_r.phase + 2'h1;
						if (s_r.phase == 2'h3) begin
							s_nxt.st = H_BIT;
							s_nxt.phase = 2'h0;
							s_nxt.bitCnt = 4'h0;
						end
					end
					H_STOP: begin
						s_nxt.phase = s_r.phase + 2'h1;
						if (s_r.phase == 2'h2) begin
							s_nxt.st = H_IDLE;
						end
					end
					default: begin
						if (s_r.phase == 2'h0) begin
							s_nxt.phase = 2'h1;
						end else if (s_r.bitCnt < qpi_pkg::BITS_PER_BYTE) begin
							// Data changes only in the low half
							s_nxt.phase = 2'h0;
							s_nxt.tx = {s_r.tx[6:0], s_r.sdaS2};
							s_nxt.bitCnt = s_r.bitCnt + 4'h1;
						end else begin
							s_nxt.phase = 2'h0;
							s_nxt.bitCnt = 4'h0;
							if (s_r.step != S_RD && s_r.sdaS2) begin
								s_nxt.nack = 1'b1;
								s_nxt.st = H_STOP;
							end else begin
								case (s_r.step)
									S_ID: begin
										s_nxt.step = S_ADDR;
										s_nxt.tx = s_r.regAddr;
									end
									S_ADDR: begin
										if (s_r.isRead) begin
											s_nxt.step = S_ID2;
											s_nxt.tx = idByte(s_r.strap, qpi_pkg::DIR_READ);
											s_nxt.st = H_START;
										end else begin
											s_nxt.step = S_WDATA;
											s_nxt.tx = s_r.wdata;
										end
									end
									S_WDATA: begin
										s_nxt.st = H_STOP;
									end
									S_ID2: begin
										s_nxt.step = S_RD;
									end
									default: begin
										s_nxt.rdata[{s_r.rdIdx, 3'h0} +: 8] = s_r.tx;
										if (s_r.rdIdx == s_r.rdLast) begin
											s_nxt.st = H_STOP;
										end else begin
											s_nxt.rdIdx = s_r.rdIdx + 2'h1;
										end
									end
								endcase
							end
						end
					end
				endcase
			end
		end
		{s_nxt.sclOe, s_nxt.sdaOe} = lineDrive(s_nxt);
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (srst) begin
			s_r <= '0;
			s_r.sdaS1 <= 1'b1;
			s_r.sdaS2 <= 1'b1;
			s_r.st <= H_IDLE;
			s_r.step <= S_ID;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign waitrequest = (read || write) && !s_r.resp;
	assign readdata = s_r.rdReg;
	assign bus.hostSclOe = s_r.sclOe;
	assign bus.hostSdaOe = s_r.sdaOe;
endmodule

// *** tb/qpi_props.sv ***
// Checker on the two-wire link between master and wiper device.
// Assumes raw link signals from the shared interface, clk domain only.
`timescale 1ns/1ps
module qpi_props (
	input wire logic clk,
	input wire logic srst,
	input wire logic hostSclOe,
	input wire logic hostSdaOe,
	input wire logic devSdaOe,
	input wire logic scl,
	input wire logic sda
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	////////////////////////////////////////////////////////////////////////////
	logic sclPrev_r;
	logic sdaPrev_r;
	logic inFrame_r;
	logic startSeen;
	logic stopSeen;
	assign startSeen = scl && sclPrev_r && sdaPrev_r && !sda;
	assign stopSeen = scl && sclPrev_r && !sdaPrev_r && sda;
	always_ff @(posedge clk) begin
		sclPrev_r <= scl;
		sdaPrev_r <= sda;
		if (srst) begin
			inFrame_r <= 1'h0;
		end else if (startSeen) begin
			inFrame_r <= 1'h1;
		end else if (stopSeen) begin
			inFrame_r <= 1'h0;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	property p_release_idle;
		$fell(srst) |-> !hostSclOe && !hostSdaOe && scl && sda;
	endproperty
	property p_settle_quiet;
		$fell(srst) |-> (!devSdaOe) [*8];
	endproperty
	property p_dev_low_phase;
		$changed(devSdaOe) |-> !scl && !$past(scl);
	endproperty
	property p_scl_high;
		$rose(scl) |-> scl [*4];
	endproperty
	property p_scl_low;
		$fell(scl) |-> (!scl) [*4];
	endproperty
	property p_dev_in_frame;
		devSdaOe |-> inFrame_r;
	endproperty
	property p_stop_release;
		stopSeen |-> (!devSdaOe) [*8];
	endproperty
	property p_start_clock;
		startSeen |-> hostSdaOe ##[1:8] !scl;
	endproperty
	property p_host_low_phase;
		$changed(hostSdaOe) |-> !scl || startSeen || stopSeen;
	endproperty
	a_release_idle: assert property (p_release_idle)
		else $error("link not idle after reset");
	a_settle_quiet: assert property (p_settle_quiet)
		else $error("device drove data while settling");
	a_dev_low_phase: assert property (p_dev_low_phase)
		else $error("device changed data while clock high");
	a_scl_high: assert property (p_scl_high)
		else $error("clock high phase too short");
	a_scl_low: assert property (p_scl_low)
		else $error("clock low phase too short");
	a_dev_in_frame: assert property (p_dev_in_frame)
		else $error("device drove data outside a frame");
	a_stop_release: assert property (p_stop_release)
		else $error("device drove data after stop");
	a_start_clock: assert property (p_start_clock)
		else $error("no clock after start");
	a_host_low_phase: assert property (p_host_low_phase)
		else $error("master changed data while clock high");
	c_ack: cover property ($rose(devSdaOe));
	c_start: cover property (startSeen);
	c_stop: cover property (stopSeen);
endmodule

// *** tb/quad_pot_i2c_slave_tb_top.sv ***
// Bench joining master and wiper device over the shared link.
// Assumes a 20 MHz clock and software access over Avalon-MM.
`timescale 1ns/1ps
module quad_pot_i2c_slave_tb_top;
	logic clk = 1'h0;
	logic srst = 1'h1;
	logic [2:0] address = 3'h0;
	logic read = 1'h0;
	logic write = 1'h0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic waitrequest;
	logic strapHi = 1'h1;
	logic strapLo = 1'h0;
	logic [3:0][7:0] wiperPos;
	int n_mismatch = 0;
	int compares = 0;
	int cycles = 0;
	logic sclP = 1'h1;
	logic sdaP = 1'h1;
	logic [7:0] bitCnt = 8'h0;
	logic [7:0] sh = 8'h0;
	logic [7:0] idByte = 8'h0;
	logic ackBit = 1'h1;
	qpi_if bus();
	qpi_host i_qpi_host (.clk(clk), .srst(srst), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .bus(bus));
	qpi_device i_qpi_device (.clk(clk), .srst(srst), .bus(bus), .addrStrapHi(strapHi),
		.addrStrapLo(strapLo), .wiperPos(wiperPos));
	qpi_props i_qpi_props (.clk(clk), .srst(srst), .hostSclOe(bus.hostSclOe),
		.hostSdaOe(bus.hostSdaOe), .devSdaOe(bus.devSdaOe), .scl(bus.scl), .sda(bus.sda));
	always #25 clk = !clk;
	////////////////////////////////////////////////////////////////////////////
	// Wire monitor: first byte after each start and its ninth bit
	always @(posedge clk) begin
		sclP <= bus.scl;
		sdaP <= bus.sda;
		if (bus.scl && sclP && sdaP && !bus.sda) begin
			bitCnt <= 8'h0;
		end else if (bus.scl && !sclP) begin
			bitCnt <= bitCnt + 8'h1;
			sh <= {sh[6:0], bus.sda};
			if (bitCnt == 8'h7) begin
				idByte <= {sh[6:0], bus.sda};
			end
			if (bitCnt == 8'h8) begin
				ackBit <= bus.sda;
			end
		end
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			n_mismatch++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic stop_test;
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic av(input logic doWrite, input logic [2:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		write <= doWrite;
		read <= !doWrite;
		address <= a;
		writedata <= d;
		do @(posedge clk); while (waitrequest !== 1'h0);
		q = readdata;
		write <= 1'h0;
		read <= 1'h0;
	endtask
	task automatic run(input logic rd, input logic [7:0] ta, input logic [7:0] wd,
		input logic [1:0] n, input logic [1:0] st, output logic [31:0] q, output logic nk);
		logic [31:0] s;
		av(1'h1, qpi_pkg::REG_TADDR, {24'h0, ta}, s);
		av(1'h1, qpi_pkg::REG_WDATA, {24'h0, wd}, s);
		av(1'h1, qpi_pkg::REG_STRAP, {30'h0, st}, s);
		av(1'h1, qpi_pkg::REG_CTRL, {28'h0, n, rd, 1'h1}, s);
		do av(1'h0, qpi_pkg::REG_STATUS, 32'h0, s); while (s[qpi_pkg::STAT_BUSY] !== 1'h0);
		nk = s[qpi_pkg::STAT_NACK];
		av(1'h0, qpi_pkg::REG_RDATA, 32'h0, q);
	endtask
	function automatic logic [7:0] wv(input int i);
		return 8'(i * 32'h55);
	endfunction
	function automatic logic [7:0] idExp(input logic [1:0] st, input logic dir);
		return {qpi_pkg::TYPE_CODE, st, dir};
	endfunction
	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		logic [31:0] q;
		logic nk;
		for (int i = 0; i < 4; i++) begin
			chk(32'(wiperPos[i]), 32'h80);
		end
		chk(32'(bus.sda), 32'h1);
		av(1'h0, 3'h6, 32'h0, q);
		chk(q, 32'h0);
		run(1'h1, 8'h00, 8'h00, 2'h3, 2'h2, q, nk);
		chk(q, 32'h80808080);
		chk(32'(nk), 32'h0);
		av(1'h0, qpi_pkg::REG_CTRL, 32'h0, q);
		chk(q, 32'he);
		av(1'h0, qpi_pkg::REG_STRAP, 32'h0, q);
		chk(q, 32'h2);
	endtask
	task automatic t_write;
		logic [31:0] q;
		logic nk;
		for (int i = 0; i < 4; i++) begin
			run(1'h0, 8'(i), wv(i), 2'h0, 2'h2, q, nk);
			chk(32'(nk), 32'h0);
			chk(32'(wiperPos[i]), 32'(wv(i)));
			chk(32'(idByte), 32'(idExp(2'h2, qpi_pkg::DIR_WRITE)));
			chk(32'(ackBit), 32'h0);
			chk(32'({bus.scl, bus.sda}), 32'h3);
		end
		for (int j = 0; j < 4; j++) begin
			chk(32'(wiperPos[j]), 32'(wv(j)));
		end
	endtask
	task automatic t_read_wrap;
		logic [31:0] q;
		logic nk;
		run(1'h1, 8'h02, 8'h00, 2'h3, 2'h2, q, nk);
		chk(q, {wv(1), wv(0), wv(3), wv(2)});
		chk(32'(idByte), 32'(idExp(2'h2, qpi_pkg::DIR_READ)));
		chk(32'(ackBit), 32'h0);
		run(1'h1, 8'h03, 8'h00, 2'h1, 2'h2, q, nk);
		chk({16'h0, q[15:0]}, {16'h0, wv(0), wv(3)});
	endtask
	task automatic t_bad_addr;
		logic [31:0] q;
		logic nk;
		run(1'h0, 8'h04, 8'h99, 2'h0, 2'h2, q, nk);
		chk(32'(nk), 32'h1);
		chk(32'(wiperPos), {wv(3), wv(2), wv(1), wv(0)});
		run(1'h0, 8'h01, 8'h42, 2'h0, 2'h2, q, nk);
		chk(32'(wiperPos[1]), 32'h42);
	endtask
	task automatic t_bad_id;
		logic [31:0] q;
		logic nk;
		run(1'h0, 8'h00, 8'h77, 2'h0, 2'h1, q, nk);
		chk(32'(nk), 32'h1);
		chk(32'(ackBit), 32'h1);
		chk(32'(wiperPos[0]), 32'(wv(0)));
		@(posedge clk);
		strapHi <= 1'h0;
		strapLo <= 1'h1;
		run(1'h0, 8'h00, 8'h77, 2'h0, 2'h1, q, nk);
		chk(32'(nk), 32'h0);
		chk(32'(wiperPos[0]), 32'h77);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clk);
		srst <= 1'h0;
		repeat (2) @(posedge clk);
		t_reset();
		t_write();
		t_read_wrap();
		t_bad_addr();
		t_bad_id();
		stop_test();
	end
endmodule
